// ===== hdl/rotate_defs.svh
// constant definitions for the immediate rotate unit
`ifndef ROTATE_DEFS_SVH
`define ROTATE_DEFS_SVH
`define ROT_DATA_W 16
`define ROT_BYTE_W 8
`define ROT_COUNT_W 8
`define ROT_COUNT_ONE 8'h01
`define ROT_COUNT_ZERO 8'h00
`define ROT_DATA_ZERO 16'h0000
`define ROT_BYTE_MASK 16'h00FF
`define ROT_WORD_MASK 16'hFFFF
`endif

// ===== hdl/rotate_pkg.sv
// types shared by the immediate rotate unit
package rotate_pkg;
   typedef enum logic [1:0] {
      ROTATE_LEFT_PLAIN = 2'h0,
      ROTATE_RIGHT_PLAIN = 2'h1,
      ROTATE_LEFT_THROUGH_CARRY = 2'h2,
      ROTATE_RIGHT_THROUGH_CARRY = 2'h3
   } rot_op_t;
   typedef enum logic [1:0] {
      COUNT_FROM_ONE = 2'h0,
      COUNT_FROM_IMMEDIATE = 2'h1,
      COUNT_FROM_LOW_BYTE_REG = 2'h2
   } count_src_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_DONE = 2'h3
   } rot_state_t;
endpackage : rotate_pkg

// ===== hdl/rotate_step.sv
// single-bit rotate step for byte or word operands
`include "rotate_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rotate_step #(
   parameter int DATA_W = 16,
   parameter int BYTE_W = 8
) (
   // operand in
   input wire logic [DATA_W-1:0] valueIn,
   input wire logic carryIn,
   input wire rotate_pkg::rot_op_t op,
   input wire logic wordMode,
   // operand out
   output logic [DATA_W-1:0] valueOut,
   output logic carryOut
);
   import rotate_pkg::*;
   logic topBit;
   logic insertBit;
   logic [DATA_W-1:0] shifted;

   // one step; the top bit position follows the operand width
   always_comb
   begin
      topBit = wordMode ? valueIn[DATA_W-1] : valueIn[BYTE_W-1];
      carryOut = carryIn;
      insertBit = 1'b0;
      shifted = valueIn;
      case (op)
         ROTATE_LEFT_PLAIN:
         begin
            shifted = {valueIn[DATA_W-2:0], topBit};
         end
         ROTATE_RIGHT_PLAIN:
         begin
            shifted = {1'b0, valueIn[DATA_W-1:1]};
            insertBit = valueIn[0];
         end
         ROTATE_LEFT_THROUGH_CARRY:
         begin
            shifted = {valueIn[DATA_W-2:0], carryIn};
            carryOut = topBit;
         end
         default:
         begin
            shifted = {1'b0, valueIn[DATA_W-1:1]};
            insertBit = carryIn;
            carryOut = valueIn[0];
         end
      endcase
      // right forms place the incoming bit at the width's top bit
      if (op == ROTATE_RIGHT_PLAIN || op == ROTATE_RIGHT_THROUGH_CARRY)
      begin
         if (wordMode)
            shifted[DATA_W-1] = insertBit;
         else
            shifted[BYTE_W-1] = insertBit;
      end
      // byte operands never leak into the upper byte
      valueOut = wordMode ? shifted : (shifted & `ROT_BYTE_MASK);
   end
endmodule : rotate_step
`default_nettype wire

// ===== hdl/immediate_rotate_unit.sv
// iterative rotate datapath: plain and through-carry, byte or word
`include "rotate_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module immediate_rotate_unit #(
   parameter int DATA_W = `ROT_DATA_W,
   parameter int BYTE_W = `ROT_BYTE_W,
   parameter int COUNT_W = `ROT_COUNT_W
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // request from execution control
   input wire logic start,
   input wire rotate_pkg::rot_op_t op,
   input wire logic wordMode,
   input wire rotate_pkg::count_src_t countSrc,
   input wire logic [COUNT_W-1:0] immediateCount,
   input wire logic [COUNT_W-1:0] countLowByteRegister,
   input wire logic [DATA_W-1:0] destData,
   input wire logic destIsMem,
   input wire logic carryFlagIn,
   // answer
   output logic busy,
   output logic done,
   output logic [DATA_W-1:0] resultData,
   output logic carryFlagOut,
   output logic writeReg,
   output logic writeMem
);
   import rotate_pkg::*;

   rot_state_t state_reg, state_next;
   logic [DATA_W-1:0] data_reg, data_next;
   logic carry_reg, carry_next;
   logic [COUNT_W-1:0] count_reg, count_next;
   rot_op_t op_reg, op_next;
   logic word_reg, word_next;
   logic mem_reg, mem_next;
   logic [DATA_W-1:0] stepValue;
   logic stepCarry;
   logic [COUNT_W-1:0] startCount;

   // the step is reused once per count: small area, count+2 cycles latency
   rotate_step #(
      .DATA_W(DATA_W),
      .BYTE_W(BYTE_W)
   ) u_step (
      .valueIn(data_reg),
      .carryIn(carry_reg),
      .op(op_reg),
      .wordMode(word_reg),
      .valueOut(stepValue),
      .carryOut(stepCarry)
   );

   // count selection at the request
   always_comb
   begin
      if (countSrc == COUNT_FROM_IMMEDIATE)
         startCount = immediateCount;
      else if (countSrc == COUNT_FROM_LOW_BYTE_REG)
         startCount = countLowByteRegister;
      else
         startCount = `ROT_COUNT_ONE;
   end

   // next-state and datapath values
   always_comb
   begin
      state_next = state_reg;
      data_next = data_reg;
      carry_next = carry_reg;
      count_next = count_reg;
      op_next = op_reg;
      word_next = word_reg;
      mem_next = mem_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (start)
            begin
               data_next = wordMode ? destData : (destData & `ROT_BYTE_MASK);
               carry_next = carryFlagIn;
               count_next = startCount;
               op_next = op;
               word_next = wordMode;
               mem_next = destIsMem;
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            // a zero count leaves operand and carry untouched
            if (count_reg == `ROT_COUNT_ZERO)
               state_next = ST_DONE;
            else
            begin
               data_next = stepValue;
               carry_next = stepCarry;
               count_next = count_reg - `ROT_COUNT_ONE;
            end
         end
         default:
            state_next = ST_IDLE;
      endcase
   end

   // state and datapath registers; reset clears the answer so nothing stale is written back
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_reg <= ST_IDLE;
         data_reg <= `ROT_DATA_ZERO;
         carry_reg <= 1'b0;
         count_reg <= `ROT_COUNT_ZERO;
         op_reg <= ROTATE_LEFT_PLAIN;
         word_reg <= 1'b0;
         mem_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         data_reg <= data_next;
         carry_reg <= carry_next;
         count_reg <= count_next;
         op_reg <= op_next;
         word_reg <= word_next;
         mem_reg <= mem_next;
      end
   end

   // answer: result and carry straight from flops, strobes decoded from state
   assign busy = (state_reg != ST_IDLE);
   assign done = (state_reg == ST_DONE);
   assign resultData = data_reg;
   assign carryFlagOut = carry_reg;
   assign writeReg = done && !mem_reg;
   assign writeMem = done && mem_reg;

   // checks
   chk_rol_byte_step: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg != `ROT_COUNT_ZERO && op_reg == ROTATE_LEFT_PLAIN && !word_reg
      |=> data_reg[BYTE_W-1:0] == {$past(data_reg[BYTE_W-2:0]), $past(data_reg[BYTE_W-1])})
      else $error("plain left byte step wrong");
   chk_ror_word_step: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg != `ROT_COUNT_ZERO && op_reg == ROTATE_RIGHT_PLAIN && word_reg
      |=> data_reg == {$past(data_reg[0]), $past(data_reg[DATA_W-1:1])})
      else $error("plain right word step wrong");
   chk_rcl_carry_move: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg != `ROT_COUNT_ZERO && op_reg == ROTATE_LEFT_THROUGH_CARRY && word_reg
      |=> carry_reg == $past(data_reg[DATA_W-1]) && data_reg[0] == $past(carry_reg))
      else $error("left through carry step wrong");
   chk_rcr_carry_move: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg != `ROT_COUNT_ZERO && op_reg == ROTATE_RIGHT_THROUGH_CARRY && !word_reg
      |=> carry_reg == $past(data_reg[0]) && data_reg[BYTE_W-1] == $past(carry_reg))
      else $error("right through carry step wrong");
   chk_imm_count_load: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && start && countSrc == COUNT_FROM_IMMEDIATE
      |=> count_reg == $past(immediateCount) && state_reg == ST_RUN)
      else $error("immediate count not taken");
   chk_one_count_run: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && start && countSrc == COUNT_FROM_ONE
      |=> state_reg == ST_RUN ##1 state_reg == ST_RUN ##1 done)
      else $error("count of one not honoured");
   chk_reg_count_load: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && start && countSrc == COUNT_FROM_LOW_BYTE_REG
      |=> count_reg == $past(countLowByteRegister))
      else $error("register count not taken");
   chk_write_back: assert property (@(posedge clk) disable iff (reset)
      done |-> (writeReg != writeMem) && writeMem == mem_reg ##1 !done && !busy && $stable(resultData))
      else $error("write back strobe wrong");
   chk_byte_upper_zero: assert property (@(posedge clk) disable iff (reset)
      busy && !word_reg |-> data_reg[DATA_W-1:BYTE_W] == `ROT_DATA_ZERO >> BYTE_W)
      else $error("byte operand touched upper byte");
   chk_zero_count_hold: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg == `ROT_COUNT_ZERO |=> done && $stable(data_reg) && $stable(carry_reg))
      else $error("zero count changed operand");
   chk_dest_capture: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && start
      |=> mem_reg == $past(destIsMem) && word_reg == $past(wordMode) && carry_reg == $past(carryFlagIn))
      else $error("destination kind or carry not captured");
   chk_ror_byte_step: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg != `ROT_COUNT_ZERO && op_reg == ROTATE_RIGHT_PLAIN && !word_reg
      |=> data_reg[BYTE_W-1:0] == {$past(data_reg[0]), $past(data_reg[BYTE_W-1:1])})
      else $error("plain right byte step wrong");
   chk_plain_carry_keep: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && (op_reg == ROTATE_LEFT_PLAIN || op_reg == ROTATE_RIGHT_PLAIN)
      |=> $stable(carry_reg))
      else $error("plain rotate changed carry");
   chk_count_step: assert property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && count_reg != `ROT_COUNT_ZERO
      |=> state_reg == ST_RUN && count_reg == $past(count_reg) - `ROT_COUNT_ONE)
      else $error("step count not decremented");

   // main scenarios reached
   cov_word_rcl: cover property (@(posedge clk) disable iff (reset)
      done && word_reg && op_reg == ROTATE_LEFT_THROUGH_CARRY);
   cov_byte_ror_mem: cover property (@(posedge clk) disable iff (reset)
      writeMem && !word_reg && op_reg == ROTATE_RIGHT_PLAIN);
   cov_zero_count: cover property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && start && startCount == `ROT_COUNT_ZERO ##2 done);
   cov_reg_count_max: cover property (@(posedge clk) disable iff (reset)
      state_reg == ST_IDLE && start && countSrc == COUNT_FROM_LOW_BYTE_REG && &countLowByteRegister);
   cov_start_refused: cover property (@(posedge clk) disable iff (reset)
      state_reg == ST_RUN && start);
endmodule : immediate_rotate_unit
`default_nettype wire

// ===== testbench/immediate_rotate_unit_tb_top.sv
// self-checking testbench for the immediate rotate unit
`timescale 1ns/1ps
`default_nettype none
module immediate_rotate_unit_tb_top;
   import rotate_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0;
   rot_op_t op = ROTATE_LEFT_PLAIN;
   logic wordMode = 1'b0;
   count_src_t countSrc = COUNT_FROM_ONE;
   logic [7:0] immediateCount = 8'h00;
   logic [7:0] countLowByteRegister = 8'h00;
   logic [15:0] destData = 16'h0000;
   logic destIsMem = 1'b0;
   logic carryFlagIn = 1'b0;
   logic busy, done, carryFlagOut, writeReg, writeMem;
   logic [15:0] resultData;
   int fails = 0;
   int checks_done = 0;

   // free-running 25 MHz clock
   always #20 clk = ~clk;

   immediate_rotate_unit uut (.clk(clk), .reset(reset), .start(start), .op(op), .wordMode(wordMode),
      .countSrc(countSrc), .immediateCount(immediateCount), .countLowByteRegister(countLowByteRegister),
      .destData(destData), .destIsMem(destIsMem), .carryFlagIn(carryFlagIn), .busy(busy), .done(done),
      .resultData(resultData), .carryFlagOut(carryFlagOut), .writeReg(writeReg), .writeMem(writeMem));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : check

   // reference rotate, one step per count; upper byte kept clear in byte mode
   function automatic logic [16:0] ref_rot(input rot_op_t o, input logic w, input logic [7:0] n,
      input logic [15:0] d, input logic c);
      logic [15:0] v;
      logic cy, b;
      int t;
      t = w ? 15 : 7;
      v = w ? d : {8'h00, d[7:0]};
      cy = c;
      for (int i = 0; i < n; i++)
      begin
         case (o)
            ROTATE_LEFT_PLAIN:
            begin
               b = v[t];
               v = v << 1;
               v[0] = b;
            end
            ROTATE_RIGHT_PLAIN:
            begin
               b = v[0];
               v = v >> 1;
               v[t] = b;
            end
            ROTATE_LEFT_THROUGH_CARRY:
            begin
               b = v[t];
               v = v << 1;
               v[0] = cy;
               cy = b;
            end
            default:
            begin
               b = v[0];
               v = v >> 1;
               v[t] = cy;
               cy = b;
            end
         endcase
         if (!w) v[15:8] = 8'h00;
      end
      return {cy, v};
   endfunction : ref_rot

   // one whole operation; poke re-requests mid-run, which must be ignored
   task automatic run_op(input rot_op_t o, input logic w, input count_src_t s, input logic [7:0] imm,
      input logic [7:0] cr, input logic [15:0] d, input logic m, input logic c, input bit poke);
      logic [7:0] n;
      logic [16:0] e;
      int k;
      n = (s == COUNT_FROM_IMMEDIATE) ? imm : (s == COUNT_FROM_LOW_BYTE_REG) ? cr : 8'h01;
      e = ref_rot(rot_op_t'(o), w, n, d, c);
      @(negedge clk);
      op = o; wordMode = w; countSrc = s; immediateCount = imm; countLowByteRegister = cr;
      destData = d; destIsMem = m; carryFlagIn = c; start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      k = 0;
      check({31'h0, busy}, 32'h1);
      while (done !== 1'b1 && k < 300)
      begin
         @(negedge clk);
         k++;
         if (poke && k == 2)
         begin
            start = 1'b1;
            destData = ~d;
         end
         else
            start = 1'b0;
      end
      check(k, n + 1);
      check({16'h0, resultData}, {16'h0, e[15:0]});
      check({31'h0, carryFlagOut}, {31'h0, e[16]});
      check({30'h0, writeReg, writeMem}, {30'h0, !m, m});
      @(negedge clk);
      check({29'h0, done, busy, writeReg | writeMem}, 32'h0);
      check({16'h0, resultData}, {16'h0, e[15:0]});
   endtask : run_op

   task automatic test_reset();
      check({16'h0, resultData}, 32'h0);
      check({28'h0, busy, done, writeReg | writeMem, carryFlagOut}, 32'h0);
      $display("test_reset done");
   endtask : test_reset

   // plain forms, byte and word, counts crossing the operand width
   task automatic test_plain();
      logic [7:0] cnts [4] = '{8'h01, 8'h03, 8'h09, 8'h11};
      for (int w = 0; w < 2; w++)
         foreach (cnts[i])
         begin
            run_op(ROTATE_LEFT_PLAIN, w[0], COUNT_FROM_IMMEDIATE, cnts[i], 8'h00,
               16'hA581, 1'b0, 1'b1, 1'b0);
            run_op(ROTATE_RIGHT_PLAIN, w[0], COUNT_FROM_IMMEDIATE, cnts[i], 8'h00,
               16'h3C81, 1'b0, 1'b0, 1'b0);
         end
      $display("test_plain done");
   endtask : test_plain

   // through-carry forms with both carry levels; 9 and 17 wrap the widened ring
   task automatic test_carry();
      for (int c = 0; c < 2; c++)
         for (int w = 0; w < 2; w++)
         begin
            run_op(ROTATE_LEFT_THROUGH_CARRY, w[0], COUNT_FROM_LOW_BYTE_REG, 8'h00, 8'h09,
               16'h8001, 1'b0, c[0], 1'b0);
            run_op(ROTATE_RIGHT_THROUGH_CARRY, w[0], COUNT_FROM_LOW_BYTE_REG, 8'h00, 8'h11,
               16'h8001, 1'b0, c[0], 1'b0);
            run_op(ROTATE_LEFT_THROUGH_CARRY, w[0], COUNT_FROM_ONE, 8'h05, 8'h07,
               16'hC003, 1'b0, c[0], 1'b0);
            run_op(ROTATE_RIGHT_THROUGH_CARRY, w[0], COUNT_FROM_ONE, 8'h05, 8'h07,
               16'h0381, 1'b0, c[0], 1'b0);
         end
      $display("test_carry done");
   endtask : test_carry

   // every count source, with the boundary counts 0 and 255
   task automatic test_sources();
      run_op(ROTATE_LEFT_PLAIN, 1'b1, COUNT_FROM_IMMEDIATE, 8'h00, 8'h04, 16'h1234, 1'b0, 1'b1, 1'b0);
      run_op(ROTATE_LEFT_PLAIN, 1'b1, COUNT_FROM_IMMEDIATE, 8'h05, 8'h02, 16'h1234, 1'b0, 1'b0, 1'b0);
      run_op(ROTATE_RIGHT_PLAIN, 1'b1, COUNT_FROM_ONE, 8'h06, 8'h03, 16'h1234, 1'b0, 1'b0, 1'b0);
      run_op(ROTATE_RIGHT_PLAIN, 1'b0, count_src_t'(2'h3), 8'h06, 8'h03, 16'h1201, 1'b0, 1'b0, 1'b0);
      run_op(ROTATE_LEFT_THROUGH_CARRY, 1'b1, COUNT_FROM_LOW_BYTE_REG, 8'h01, 8'h00,
         16'hBEEF, 1'b0, 1'b1, 1'b0);
      run_op(ROTATE_RIGHT_THROUGH_CARRY, 1'b0, COUNT_FROM_LOW_BYTE_REG, 8'h01, 8'hFF,
         16'h00B5, 1'b0, 1'b1, 1'b0);
      $display("test_sources done");
   endtask : test_sources

   // memory destination, and a second request ignored while busy
   task automatic test_dest_busy();
      run_op(ROTATE_LEFT_PLAIN, 1'b0, COUNT_FROM_ONE, 8'h00, 8'h00, 16'h5A80, 1'b1, 1'b0, 1'b0);
      run_op(ROTATE_RIGHT_THROUGH_CARRY, 1'b1, COUNT_FROM_IMMEDIATE, 8'h06, 8'h00,
         16'h7F01, 1'b1, 1'b1, 1'b1);
      run_op(ROTATE_LEFT_PLAIN, 1'b1, COUNT_FROM_IMMEDIATE, 8'h04, 8'h00, 16'h0F0F, 1'b0, 1'b0, 1'b1);
      $display("test_dest_busy done");
   endtask : test_dest_busy

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   // watchdog: the tests need well under 5000 cycles
   initial
   begin
      #(40 * 20000);
      fails++;
      print_verdict();
   end

   // main sequence: reset held for 16 cycles, then the scenarios
   initial
   begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      test_reset();
      test_plain();
      test_carry();
      test_sources();
      test_dest_busy();
      print_verdict();
   end
endmodule : immediate_rotate_unit_tb_top
`default_nettype wire
